// file: logic/pir_cfg.svh
/*
 Offsets, field positions, reset values and identity defaults for the
 identification and interrupt register block. Assumes nothing else.
*/
`ifndef PIR_CFG_SVH
`define PIR_CFG_SVH
`define PIR_PRINTED_PART_LOW 8'h00
`define PIR_PRINTED_REV_HIGH 8'h01
`define PIR_PRINTED_FLAGS 8'h02
`define PIR_PRINTED_MASK 8'h03
`define PIR_IDX_PART_LOW 4'h0
`define PIR_IDX_REV_HIGH 4'h1
`define PIR_IDX_FLAGS 4'h2
`define PIR_IDX_MASK 4'h3
`define PIR_IDX_CAUSE 4'h4
`define PIR_BIT_FAULT 7
`define PIR_BIT_SHUTDOWN 3
`define PIR_BIT_DIE_HOT 0
`define PIR_ACTIVE_BITS 8'h89
`define PIR_FLAGS_RESET 8'h00
`define PIR_MASK_RESET 8'hff
`define PIR_CAUSE_BITS 4'hf
`define PIR_PART_CODE_DEFAULT 12'h5a5
`define PIR_REVISION_DEFAULT 2'h2
`define PIR_VARIANT_DEFAULT 2'h1
`endif

// file: logic/pir_pkg.sv
/*
 Types for the identification and interrupt register block.
 Assumes the configuration header is included before use of its values.
*/
package pir_pkg;
  typedef enum logic [1:0] {
    PIR_VARIANT_A,
    PIR_VARIANT_B,
    PIR_VARIANT_C,
    PIR_VARIANT_D
  } pir_variant_t;
  typedef struct packed {
    logic rail_fault;
    logic die_critical;
    logic die_hot;
    logic shutdown_done;
    logic [3:0] cause_set;
  } pir_events_t;
  typedef enum logic [1:0] {
    PIR_RD_IDLE,
    PIR_RD_RESP
  } pir_rd_state_t;
endpackage

// file: logic/pir_regs.sv
/*
 Identification, interrupt flag, interrupt mask and shutdown cause registers
 behind an AXI4-Lite slave, with one level interrupt output.
 Assumes event inputs are synchronous to CLK_SYS and may be pulses or levels.
*/
// The AXI4-Lite register port was decided locally.
// Overview of operation
// - Word 0 reads the low eight part-code bits as two nibbles, fixed.
// - Word 1 low nibble reads the upper four part-code bits, fixed.
// - Word 1 bits 7:6 read the two-bit silicon revision, fixed.
// - Word 1 bits 5:4 read the memory variant code A to D, fixed.
// - The flag word resets to zero and only bits 7, 3 and 0 are live.
// - A rail power fault or critical die heat sets flag bit 7.
// - Flags read one while set and clear only on a written one.
// - A completed shutdown sets flag bit 3.
// - The shutdown flag is not cleared while any cause bit is set.
// - Die heat past the hot threshold sets flag bit 0.
// - The mask word resets to all ones with writable bits 7, 3 and 0.
// - A mask bit at one blocks its flag, at zero lets it signal.
// - Setting any shutdown cause bit also sets the shutdown flag.
`timescale 1ns/1ns
`default_nettype none
`include "pir_cfg.svh"
module pir_regs #(
  parameter logic [11:0] PART_CODE = `PIR_PART_CODE_DEFAULT,
  parameter logic [1:0] REVISION = `PIR_REVISION_DEFAULT,
  parameter pir_pkg::pir_variant_t VARIANT = pir_pkg::PIR_VARIANT_B
) (
  input wire logic CLK_SYS,
  input wire logic RESET_N,
  input wire pir_pkg::pir_events_t EVENTS,
  input wire logic [5:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [5:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  output logic IRQ_OUT
);
  import pir_pkg::*;

  // Maps a byte address to a register index; beyond the map gives 4'hf.
  function automatic logic [3:0] word_index(input logic [5:0] addr);
    if (addr[5:2] <= `PIR_IDX_CAUSE) begin
      word_index = addr[5:2];
    end else begin
      word_index = 4'hf;
    end
  endfunction

  logic [7:0] flags;
  logic [7:0] mask;
  logic [3:0] cause;
  logic aw_held, w_held, bvalid;
  logic [5:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic [1:0] bresp;
  logic [7:0] next_flags, next_mask;
  logic [3:0] next_cause;
  logic next_aw_held, next_w_held, next_bvalid;
  logic [5:0] next_aw_addr;
  logic [31:0] next_w_data;
  logic [3:0] next_w_strb;
  logic [1:0] next_bresp;
  logic wr_fire;
  logic [3:0] wr_idx;
  logic [7:0] wr_byte;
  logic [7:0] flag_set, flag_clr;
  logic [3:0] cause_clr;
  logic [7:0] id_low, id_high;

  pir_rd_state_t rd_state, next_rd_state;
  logic [31:0] rdata, next_rdata;
  logic [1:0] rresp, next_rresp;

  assign id_low = PART_CODE[7:0];
  assign id_high = {REVISION, 2'(VARIANT), PART_CODE[11:8]};

  assign S_AXI_AWREADY = !aw_held;
  assign S_AXI_WREADY = !w_held;
  assign S_AXI_BVALID = bvalid;
  assign S_AXI_BRESP = bresp;
  assign wr_fire = aw_held && w_held && !bvalid;
  assign wr_idx = word_index(aw_addr);
  assign wr_byte = w_strb[0] ? w_data[7:0] : 8'h00;

  always_comb begin
    next_aw_held = aw_held;
    next_w_held = w_held;
    next_aw_addr = aw_addr;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_bvalid = bvalid;
    next_bresp = bresp;
    if (S_AXI_AWVALID && !aw_held) begin
      next_aw_held = 1'b1;
      next_aw_addr = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && !w_held) begin
      next_w_held = 1'b1;
      next_w_data = S_AXI_WDATA;
      next_w_strb = S_AXI_WSTRB;
    end
    if (wr_fire) begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = (wr_idx == 4'hf) ? 2'h3 : 2'h0;
    end
    if (bvalid && S_AXI_BREADY) begin
      next_bvalid = 1'b0;
    end
  end

  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 6'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      bvalid <= 1'b0;
      bresp <= 2'h0;
    end else begin
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      aw_addr <= next_aw_addr;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
    end
  end

  always_comb begin
    flag_set = 8'h00;
    flag_set[`PIR_BIT_FAULT] = EVENTS.rail_fault | EVENTS.die_critical;
    flag_set[`PIR_BIT_SHUTDOWN] = EVENTS.shutdown_done |
                                  (|EVENTS.cause_set);
    flag_set[`PIR_BIT_DIE_HOT] = EVENTS.die_hot;
    flag_clr = 8'h00;
    cause_clr = 4'h0;
    if (wr_fire && wr_idx == `PIR_IDX_FLAGS) begin
      flag_clr = wr_byte & `PIR_ACTIVE_BITS;
    end
    if (|cause) begin
      flag_clr[`PIR_BIT_SHUTDOWN] = 1'b0;
    end
    if (wr_fire && wr_idx == `PIR_IDX_CAUSE) begin
      cause_clr = wr_byte[3:0];
    end
    // live bits only, set wins over clear
    next_flags = ((flags & ~flag_clr) | flag_set) & `PIR_ACTIVE_BITS;
    next_cause = ((cause & ~cause_clr) | EVENTS.cause_set) & `PIR_CAUSE_BITS;
    next_mask = mask;
    if (wr_fire && wr_idx == `PIR_IDX_MASK && w_strb[0]) begin
      next_mask = (w_data[7:0] & `PIR_ACTIVE_BITS) |
                  (`PIR_MASK_RESET & ~`PIR_ACTIVE_BITS);
    end
  end

  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      flags <= `PIR_FLAGS_RESET;
      mask <= `PIR_MASK_RESET;
      cause <= 4'h0;
    end else begin
      flags <= next_flags;
      mask <= next_mask;
      cause <= next_cause;
    end
  end

  assign IRQ_OUT = |(flags & ~mask & `PIR_ACTIVE_BITS);

  assign S_AXI_ARREADY = (rd_state == PIR_RD_IDLE);
  assign S_AXI_RVALID = (rd_state == PIR_RD_RESP);
  assign S_AXI_RDATA = rdata;
  assign S_AXI_RRESP = rresp;

  always_comb begin
    next_rd_state = rd_state;
    next_rdata = rdata;
    next_rresp = rresp;
    case (rd_state)
      PIR_RD_IDLE: begin
        if (S_AXI_ARVALID) begin
          next_rd_state = PIR_RD_RESP;
          next_rresp = 2'h0;
          case (word_index(S_AXI_ARADDR))
            `PIR_IDX_PART_LOW: next_rdata = {24'h000000, id_low};
            `PIR_IDX_REV_HIGH: next_rdata = {24'h000000, id_high};
            `PIR_IDX_FLAGS: next_rdata = {24'h000000, flags};
            `PIR_IDX_MASK: next_rdata = {24'h000000, mask};
            `PIR_IDX_CAUSE: next_rdata = {28'h0000000, cause};
            default: begin
              next_rdata = 32'h0000_0000;
              next_rresp = 2'h3;
            end
          endcase
        end
      end
      PIR_RD_RESP: begin
        if (S_AXI_RREADY) begin
          next_rd_state = PIR_RD_IDLE;
        end
      end
      default: next_rd_state = PIR_RD_IDLE;
    endcase
  end

  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      rd_state <= PIR_RD_IDLE;
      rdata <= 32'h0000_0000;
      rresp <= 2'h0;
    end else begin
      rd_state <= next_rd_state;
      rdata <= next_rdata;
      rresp <= next_rresp;
    end
  end

  a_shutdown_kept: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
    (flags[`PIR_BIT_SHUTDOWN] && (|cause)) |=> flags[`PIR_BIT_SHUTDOWN])
    else $error("shutdown flag dropped while a cause bit was set");
  a_fault_sets: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
    (EVENTS.rail_fault || EVENTS.die_critical) |=> flags[`PIR_BIT_FAULT])
    else $error("fault event did not set fault flag");
  a_hot_sets: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
    EVENTS.die_hot |=> flags[`PIR_BIT_DIE_HOT])
    else $error("die hot event did not set flag");
  a_cause_shutdown: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
    ((|EVENTS.cause_set) || EVENTS.shutdown_done) |=>
      flags[`PIR_BIT_SHUTDOWN] &&
      ((cause & $past(EVENTS.cause_set)) == $past(EVENTS.cause_set)))
    else $error("shutdown cause did not raise shutdown flag");
  a_mask_write: assert property (
    @(posedge CLK_SYS) disable iff (!RESET_N)
    (wr_fire && wr_idx == `PIR_IDX_MASK && w_strb[0]) |=>
      ((mask & `PIR_ACTIVE_BITS) ==
       ($past(w_data[7:0]) & `PIR_ACTIVE_BITS)))
    else $error("mask write did not land");
  a_flag_clear: assert property (
    @(posedge CLK_SYS) disable iff (!RESET_N)
    (wr_fire && wr_idx == `PIR_IDX_FLAGS && wr_byte[`PIR_BIT_DIE_HOT] &&
     !EVENTS.die_hot) |=> !flags[`PIR_BIT_DIE_HOT])
    else $error("die hot flag not cleared by a written one");
  a_masked_quiet: assert property (
    @(posedge CLK_SYS) disable iff (!RESET_N)
    ((mask & `PIR_ACTIVE_BITS) == `PIR_ACTIVE_BITS) |-> !IRQ_OUT)
    else $error("interrupt raised while all flags were masked");
  a_part_read: assert property (
    @(posedge CLK_SYS) disable iff (!RESET_N)
    (S_AXI_ARVALID && S_AXI_ARREADY && S_AXI_ARADDR[5:2] == 4'h0) |=>
      (S_AXI_RDATA == {24'h000000, PART_CODE[7:0]}))
    else $error("part code read returned wrong value");
  a_flag_sticky: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
    !(wr_fire && wr_idx == `PIR_IDX_FLAGS) |=>
      ((flags & $past(flags)) == $past(flags)))
    else $error("flag dropped without a clear write");
  a_reserved_zero: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
    (flags & ~`PIR_ACTIVE_BITS) == 8'h00)
    else $error("reserved flag bit set");
  a_mask_reserved: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
    (mask & ~`PIR_ACTIVE_BITS) == (`PIR_MASK_RESET & ~`PIR_ACTIVE_BITS))
    else $error("reserved mask bit changed");
  a_irq_level: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
    IRQ_OUT == ((flags[7] && !mask[7]) || (flags[3] && !mask[3]) ||
                (flags[0] && !mask[0])))
    else $error("interrupt output does not match flags and mask");
  a_id_read: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
    (S_AXI_ARVALID && S_AXI_ARREADY && S_AXI_ARADDR[5:2] == 4'h1)
      |=> S_AXI_RVALID && S_AXI_RDATA[7:0] == id_high)
    else $error("identification read returned wrong value");
endmodule
`default_nettype wire

// file: sim/pir_host.sv
/*
 Host model that reaches the register block over AXI4-Lite.
 Assumes one clock shared with the block; tasks start just after an edge.
*/
`timescale 1ns/1ns
`default_nettype none
module pir_host (
  input wire logic clk,
  output logic [5:0] awaddr,
  output logic awvalid,
  input wire logic awready,
  output logic [31:0] wdata,
  output logic [3:0] wstrb,
  output logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  output logic bready,
  output logic [5:0] araddr,
  output logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  output logic rready
);
  logic aw_t = 0, w_t = 0, b_t = 0, ar_t = 0, r_t = 0;
  logic [1:0] resp;
  logic [31:0] data;
  int hangs = 0;
  initial begin
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata} = '0;
    wstrb = 4'hf;
  end
  // Handshakes are captured at the edge so the tasks see no race.
  always @(posedge clk) begin
    {aw_t, w_t, b_t} <= {awvalid & awready, wvalid & wready, bvalid & bready};
    {ar_t, r_t} <= {arvalid & arready, rvalid & rready};
    resp <= bvalid ? bresp : rresp;
    data <= rdata;
  end
  task automatic wr(input logic [5:0] a, input logic [7:0] d,
                    output logic [1:0] r);
    int n = 0;
    awaddr <= a;
    wdata <= {24'h0, d};
    {awvalid, wvalid, bready} <= 3'b111;
    do begin
      @(posedge clk);
      #1;
      if (aw_t) awvalid <= 1'b0;
      if (w_t) wvalid <= 1'b0;
      n++;
    end while (!b_t && n < 50);
    bready <= 1'b0;
    r = resp;
    if (n >= 50) begin
      hangs++;
      $display("BAD %0t write response timed out", $time);
    end
    // One idle edge keeps a following call from re-raising in this step.
    @(posedge clk);
    #1;
  endtask
  task automatic rd(input logic [5:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    int n = 0;
    araddr <= a;
    {arvalid, rready} <= 2'b11;
    do begin
      @(posedge clk);
      #1;
      if (ar_t) arvalid <= 1'b0;
      n++;
    end while (!r_t && n < 50);
    rready <= 1'b0;
    {d, r} = {data, resp};
    if (n >= 50) begin
      hangs++;
      $display("BAD %0t read response timed out", $time);
    end
    // One idle edge keeps a following call from re-raising in this step.
    @(posedge clk);
    #1;
  endtask
endmodule
`default_nettype wire

// file: sim/pir_regs_test.sv
/*
 Self-checking bench for the register block, driven through the host model.
 Assumes the design package and the host model are compiled first.
*/
`timescale 1ns/1ns
`default_nettype none
module pir_regs_test;
  import pir_pkg::*;
  localparam logic [11:0] PC = 12'h3c7; // Arbitrary identity value.
  localparam logic [1:0] RV = 2'h1; // Arbitrary identity value.
  localparam logic [7:0] EVB [4] = '{8'h80, 8'h40, 8'h20, 8'h10};
  localparam logic [7:0] EXF [4] = '{8'h80, 8'h80, 8'h01, 8'h08};
  logic CLK_SYS = 1'b0;
  logic RESET_N = 1'b0;
  pir_events_t EVENTS = '0;
  wire logic [5:0] aa, ra;
  wire logic [31:0] wd, rdat;
  wire logic [3:0] ws;
  wire logic [1:0] br, rr;
  wire logic av, ardy, wv, wrdy, bv, bre, rv, rrdy, arv, arr, irq;
  int failures = 0;
  int n_checks = 0;
  logic [7:0] flg = 8'h00, msk = 8'hff, v;
  logic [31:0] d;
  logic [1:0] r;
  int k;
  always #20 CLK_SYS = ~CLK_SYS;
  pir_regs #(.PART_CODE(PC), .REVISION(RV), .VARIANT(PIR_VARIANT_D)) pir_regs_i (
    .CLK_SYS(CLK_SYS), .RESET_N(RESET_N), .EVENTS(EVENTS),
    .S_AXI_AWADDR(aa), .S_AXI_AWVALID(av), .S_AXI_AWREADY(ardy),
    .S_AXI_WDATA(wd), .S_AXI_WSTRB(ws), .S_AXI_WVALID(wv),
    .S_AXI_WREADY(wrdy), .S_AXI_BRESP(br), .S_AXI_BVALID(bv),
    .S_AXI_BREADY(bre), .S_AXI_ARADDR(ra), .S_AXI_ARVALID(arv),
    .S_AXI_ARREADY(arr), .S_AXI_RDATA(rdat), .S_AXI_RRESP(rr),
    .S_AXI_RVALID(rv), .S_AXI_RREADY(rrdy), .IRQ_OUT(irq));
  pir_host host_i (.clk(CLK_SYS), .awaddr(aa), .awvalid(av), .awready(ardy),
    .wdata(wd), .wstrb(ws), .wvalid(wv), .wready(wrdy), .bresp(br),
    .bvalid(bv), .bready(bre), .araddr(ra), .arvalid(arv), .arready(arr),
    .rdata(rdat), .rresp(rr), .rvalid(rv), .rready(rrdy));
  function automatic logic exp_irq(input logic [7:0] f,
                                   input logic [7:0] m);
    return |(f & ~m & 8'h89);
  endfunction
  function automatic logic [7:0] exp_mask(input logic [7:0] w);
    return w | 8'h76;
  endfunction
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task rdc(input logic [5:0] a, input logic [31:0] exp);
    host_i.rd(a, d, r);
    chk(d, exp);
  endtask
  task irqc();
    chk({31'h0, irq}, {31'h0, exp_irq(flg, msk)});
  endtask
  task pulse(input logic [7:0] e);
    EVENTS <= pir_events_t'(e);
    @(posedge CLK_SYS);
    #1;
    EVENTS <= '0;
  endtask
  task summarize();
    failures += host_i.hangs;
    if (failures == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // A host wait that ran out ends the run through the report.
  always @(posedge CLK_SYS) begin
    if (host_i.hangs != 0) begin
      summarize();
    end
  end
  initial begin
    void'($urandom(32'ha85573a9));
    repeat (2) @(posedge CLK_SYS);
    #1;
    RESET_N <= 1'b1;
    @(posedge CLK_SYS);
    #1;
    irqc();
    rdc(6'h00, {24'h0, PC[7:0]});
    rdc(6'h04, {24'h0, RV, 2'h3, PC[11:8]});
    rdc(6'h08, 32'h0);
    rdc(6'h0c, 32'hff);
    host_i.wr(6'h00, 8'h5a, r);
    rdc(6'h00, {24'h0, PC[7:0]});
    host_i.wr(6'h3c, 8'h01, r);
    chk({30'h0, r}, 32'h3);
    host_i.rd(6'h3c, d, r);
    chk({d[29:0], r}, 32'h3);
    for (int i = 0; i < 12; i++) begin
      v = $urandom();
      host_i.wr(6'h0c, v, r);
      msk = exp_mask(v);
      rdc(6'h0c, {24'h0, msk});
      pulse(EVB[i % 4]);
      flg = flg | EXF[i % 4];
      rdc(6'h08, {24'h0, flg});
      irqc();
      v = ~EXF[i % 4] & $urandom();
      host_i.wr(6'h08, v, r);
      flg = flg & ~v;
      rdc(6'h08, {24'h0, flg});
      host_i.wr(6'h08, EXF[i % 4], r);
      flg = 8'h00;
      rdc(6'h08, 32'h0);
      irqc();
    end
    k = $urandom_range(3, 0);
    pulse(8'h01 << k);
    flg = 8'h08;
    rdc(6'h08, 32'h08);
    rdc(6'h10, {28'h0, 4'h1 << k});
    irqc();
    host_i.wr(6'h08, 8'h08, r);
    rdc(6'h08, 32'h08);
    host_i.wr(6'h10, {4'h0, 4'h1 << k}, r);
    rdc(6'h10, 32'h0);
    host_i.wr(6'h08, 8'h08, r);
    flg = 8'h00;
    rdc(6'h08, 32'h0);
    irqc();
    summarize();
  end
endmodule
`default_nettype wire
